// [rtl/sacc_convert_ctrl.sv]
// Contract
// - Trial bits MSB to LSB, leaving an 8-bit result.
// - Keep trial bit when sum below input; clear it when above.
// - On finish drive valid flag low and enable result outputs.
// - Raising control line floats outputs and readies register for next conversion.
// - Standby with control high: outputs floating, valid flag high.
// - Falling control edge starts conversion; flag and data unchanged meanwhile.
// - Conversion about 25 us; data valid within 500 ns of flag falling.
// - About 1.5 us after control rises, flag high and outputs float.
// - A later falling edge after blanking starts a fresh conversion.
// - Raising control during conversion halts it.
// - Halt leaves flag and data; high pulse of 2 us restarts.
// - Control held low after completion keeps presenting the result.
// - Offset input tied low: unipolar; open: bipolar with offset.
// - Bipolar result is offset binary, 00 to 80 to ff.
// - Unipolar result is straight positive-true binary.
module sacc_convert_ctrl
  import sacc_pkg::*;
(
  input  wire logic                sys_clk,       // System clock, 100 MHz
  input  wire logic                rst,           // Synchronous reset, high
  input  wire logic                blank_convert, // High blanks, falling edge converts
  input  wire logic                offset_open,   // High selects bipolar range
  input  wire logic                comp_below,    // Weighted sum below input
  output logic      [RESULT_W-1:0] dac_code,      // Trial code to the DAC
  output logic                     offset_inject, // Inject bipolar offset current
  output logic                     result_valid_n, // Result valid, active low
  output logic      [RESULT_W-1:0] data_out,      // Result pin values
  output logic      [RESULT_W-1:0] data_oe        // Result pin enables, high drives
);
  sacc_state_t         state;
  sacc_state_t         next_state;
  logic [RESULT_W-1:0] sar;
  logic [RESULT_W-1:0] next_sar;
  logic [RESULT_W-1:0] trial;
  logic [RESULT_W-1:0] next_trial;
  logic [CNT_W-1:0]    cnt;
  logic [CNT_W-1:0]    next_cnt;
  logic [CNT_W-1:0]    high_cnt;
  logic [CNT_W-1:0]    next_high_cnt;
  logic                bc_q;
  logic                valid_n;
  logic                next_valid_n;
  logic                offset_q;
  logic                next_offset_q;
  logic                load;
  logic                show;
  logic                fall;
  logic                next_bc_q;
  logic                slot_end;
  logic                blank_due;
  logic                long_high;
  logic [RESULT_W-1:0] decided;

  // Saturating increment used by both counters
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + CNT_W'(1);
  endfunction

  // Trial decision: keep the bit only when the sum was below the input
  function automatic logic [RESULT_W-1:0] decide_bit(
    input logic [RESULT_W-1:0] code,
    input logic [RESULT_W-1:0] bit_mask,
    input logic                below
  );
    decide_bit = below ? code : (code & ~bit_mask);
  endfunction

  assign fall = bc_q & ~blank_convert;

  // Slot and delay decodes shared by the sequencer
  assign slot_end  = (cnt == CNT_W'(TRIAL_CYCLES - 1));
  assign blank_due = !valid_n && (cnt >= CNT_W'(BLANK_CYCLES - 1));
  assign long_high = (high_cnt >= CNT_W'(MIN_HIGH_CYCLES));
  assign decided   = decide_bit(sar, trial, comp_below);

  // Control line sample; reset value matches the idle high level
  always_comb begin
    next_bc_q = blank_convert;
  end

  // Register the control line sample
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bc_q <= 1'b1;
    end else begin
      bc_q <= next_bc_q;
    end
  end

  // Length of the current high level, for resume or restart
  always_comb begin
    next_high_cnt = blank_convert ? sat_inc(high_cnt) : '0;
  end

  // Register the high-level length
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      high_cnt <= '0;
    end else begin
      high_cnt <= next_high_cnt;
    end
  end

  // Sequencer next state
  always_comb begin
    next_state    = state;
    next_sar      = sar;
    next_trial    = trial;
    next_cnt      = sat_inc(cnt);
    next_valid_n  = valid_n;
    next_offset_q = offset_q;
    load          = 1'b0;
    case (state)
      SACC_STANDBY: begin
        next_cnt = '0;
        // Flag rises and pins float a fixed time after the control rise
        if (blank_due) begin
          next_valid_n = 1'b1;
        end
        // An early falling edge still starts; the host keeps the blanking time
        if (fall) begin
          next_state    = SACC_CONVERT;
          next_sar      = MSB_MASK;
          next_trial    = MSB_MASK;
          next_offset_q = offset_open;
        end else if (!valid_n) begin
          // Count the blanking delay only while the flag is low
          next_cnt = sat_inc(cnt);
        end
      end
      SACC_CONVERT: begin
        // Halt wins over a slot end in the same cycle
        if (blank_convert) begin
          next_state = SACC_HALTED;
        end else if (slot_end) begin
          next_cnt = '0;
          // Decide current trial bit, then move to next lower
          next_sar = decided;
          if (trial[0]) begin
            // Last bit decided: present the result
            next_state   = SACC_PRESENT;
            next_valid_n = 1'b0;
            load         = 1'b1;
          end else begin
            next_trial = trial >> 1;
            next_sar   = decided | (trial >> 1);
          end
        end
      end
      SACC_HALTED: begin
        next_cnt = '0;
        // Flag and data untouched; a long enough pulse clears and restarts
        if (!blank_convert) begin
          // A short pulse resumes the interrupted slot from its start
          if (long_high) begin
            next_sar   = MSB_MASK;
            next_trial = MSB_MASK;
          end
          next_offset_q = offset_open;
          next_state    = SACC_CONVERT;
        end
      end
      SACC_PRESENT: begin
        // Result held until the control line rises
        if (blank_convert) begin
          next_state = SACC_STANDBY;
          // Count starts at one so the flag rises about 1.5 us after the pin
          next_cnt   = CNT_W'(1);
          next_sar   = RESULT_RST;
          next_trial = RESULT_RST;
        end else begin
          // No delay count while presenting
          next_cnt = '0;
        end
      end
      default: begin
        // Unused state code: back to standby, pins floated
        next_state   = SACC_STANDBY;
        next_valid_n = 1'b1;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state    <= SACC_STANDBY;
      sar      <= RESULT_RST;
      trial    <= RESULT_RST;
      cnt      <= '0;
      valid_n  <= 1'b1;
      offset_q <= 1'b0;
    end else begin
      state    <= next_state;
      sar      <= next_sar;
      trial    <= next_trial;
      cnt      <= next_cnt;
      valid_n  <= next_valid_n;
      offset_q <= next_offset_q;
    end
  end

  // Pins driven while the flag is low; data and enables change on the same edge as the flag
  assign show           = ~next_valid_n;

  // Trial code, mode switch and flag straight from registers
  assign dac_code       = sar;
  assign offset_inject  = offset_q;
  assign result_valid_n = valid_n;

  // Result store and three-state drivers
  sacc_result_reg u_result (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .load      (load),
    .load_data (decided),
    .show      (show),
    .data_out  (data_out),
    .data_oe   (data_oe)
  );
endmodule

// [rtl/sacc_pkg.sv]
package sacc_pkg;
  // Result width
  localparam int unsigned RESULT_W       = 8;
  // Clock rate
  localparam int unsigned CLK_MHZ        = 100;
  // Typical conversion time in ns, split evenly across the bit trials
  localparam int unsigned CONV_TIME_NS   = 25000;
  localparam int unsigned TRIAL_CYCLES   = (CONV_TIME_NS * CLK_MHZ / 1000) / RESULT_W;
  // Longest delay from valid low to data active, ns (rounded down)
  localparam int unsigned DATA_DELAY_NS  = 500;
  localparam int unsigned DATA_CYCLES    = DATA_DELAY_NS * CLK_MHZ / 1000;
  // Delay from control rise to blanking, ns
  localparam int unsigned BLANK_DELAY_NS = 1500;
  localparam int unsigned BLANK_CYCLES   = BLANK_DELAY_NS * CLK_MHZ / 1000;
  // Least high pulse that clears the converter, ns (rounded up)
  localparam int unsigned MIN_HIGH_NS    = 2000;
  localparam int unsigned MIN_HIGH_CYCLES = (MIN_HIGH_NS * CLK_MHZ + 999) / 1000;
  // Counter width
  localparam int unsigned CNT_W          = 12;
  // Reset and start values
  localparam logic [7:0]  RESULT_RST     = 8'h00;
  localparam logic [7:0]  MSB_MASK       = 8'h80;

  typedef enum logic [3:0] {
    SACC_STANDBY = 4'b0001,
    SACC_CONVERT = 4'b0010,
    SACC_HALTED  = 4'b0100,
    SACC_PRESENT = 4'b1000
  } sacc_state_t;
endpackage

// [rtl/sacc_result_reg.sv]
// Holds the finished result and drives the three-state data pins from a register
module sacc_result_reg
  import sacc_pkg::*;
(
  input  wire logic                sys_clk,  // System clock
  input  wire logic                rst,      // Synchronous reset
  input  wire logic                load,     // Capture new result
  input  wire logic [RESULT_W-1:0] load_data, // Result to capture
  input  wire logic                show,     // Enable pins
  output logic      [RESULT_W-1:0] data_out, // Result pin values
  output logic      [RESULT_W-1:0] data_oe   // Result pin enables
);
  logic [RESULT_W-1:0] store;
  logic [RESULT_W-1:0] next_store;
  logic                next_oe;

  // Next values for the stored word and enables
  always_comb begin
    next_store = load ? load_data : store;
    next_oe    = show;
  end

  // Register the result and pin enables
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      store   <= RESULT_RST;
      data_oe <= '0;
    end else begin
      store   <= next_store;
      data_oe <= {RESULT_W{next_oe}};
    end
  end

  assign data_out = store;
endmodule

// [sim/sacc_convert_ctrl_sva.sv]
module sacc_convert_ctrl_sva
  import sacc_pkg::*;
(
  input wire logic                sys_clk,        // Clock
  input wire logic                rst,            // Reset
  input wire logic                blank_convert,  // Control line
  input wire logic                offset_open,    // Range select
  input wire logic [RESULT_W-1:0] dac_code,       // Trial code
  input wire logic                offset_inject,  // Offset switch
  input wire logic                result_valid_n, // Valid flag
  input wire logic [RESULT_W-1:0] data_out,       // Result
  input wire logic [RESULT_W-1:0] data_oe         // Enables
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] hi_cnt;
  logic [11:0] next_hi_cnt;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Length of the current high level, saturating
  always_comb begin
    next_hi_cnt = blank_convert ? hi_cnt + {11'h000, hi_cnt != 12'hfff} : 12'h000;
  end
  always_ff @(posedge sys_clk) begin
    hi_cnt <= rst ? 12'h000 : next_hi_cnt;
  end

  oe_tracks_a: assert property (
    data_oe == {RESULT_W{!result_valid_n}}) else $error("enables differ from flag");
  blank_delay_a: assert property (
    $rose(blank_convert) && !result_valid_n |-> ##149 !result_valid_n ##1 result_valid_n)
    else $error("blanking delay wrong");
  hold_present_a: assert property (
    !result_valid_n && !blank_convert |=> !result_valid_n && $stable(data_out))
    else $error("result not held");
  convert_quiet_a: assert property (
    $fell(blank_convert) && result_valid_n |=> (result_valid_n && $stable(data_out))[*8])
    else $error("outputs moved at start");
  msb_first_a: assert property (
    $fell(blank_convert) && hi_cnt >= 12'h0c8 |=> dac_code == MSB_MASK)
    else $error("first trial not msb");
  inject_mode_a: assert property (
    $fell(blank_convert) && hi_cnt >= 12'h0c8 |=> offset_inject == $past(offset_open))
    else $error("offset switch wrong");
  result_load_a: assert property (
    $fell(result_valid_n) |-> data_out == dac_code) else $error("result not loaded");
  halt_freeze_a: assert property (
    $rose(blank_convert) && result_valid_n |=> (result_valid_n && $stable(dac_code))[*8])
    else $error("halt did not freeze");
endmodule

bind sacc_convert_ctrl sacc_convert_ctrl_sva u_sacc_convert_ctrl_sva (
  .sys_clk(sys_clk), .rst(rst), .blank_convert(blank_convert), .offset_open(offset_open),
  .dac_code(dac_code), .offset_inject(offset_inject), .result_valid_n(result_valid_n),
  .data_out(data_out), .data_oe(data_oe));

// [sim/sacc_front_model.sv]
module sacc_front_model
  import sacc_pkg::*;
(
  input  wire logic [RESULT_W-1:0] dac_code,  // Trial code
  input  wire logic [RESULT_W:0]   vin,       // Input in code steps
  output logic                     comp_below // Sum below input
);
  timeunit 1ns;
  timeprecision 1ns;
  // Strict compare, so an equal sum drops the bit
  assign comp_below = {1'b0, dac_code} < vin;
endmodule

// [sim/sacc_convert_ctrl_tb.sv]
module sacc_convert_ctrl_tb;
  import sacc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic                sys_clk = 1'b0;
  logic                rst = 1'b1;
  logic                blank_convert = 1'b1;
  logic                offset_open = 1'b0;
  logic                comp_below, offset_inject, result_valid_n;
  logic [RESULT_W:0]   vin = 9'h000;
  logic [RESULT_W-1:0] dac_code, data_out, data_oe;
  logic [7:0]          lfsr = 8'h1e;
  logic [8:0]          corner [4] = '{9'h000, 9'h001, 9'h081, 9'h100};
  int                  err_total = 0, samples_checked = 0, cnt;

  always #5 sys_clk = ~sys_clk;

  sacc_convert_ctrl u_sacc_convert_ctrl (.sys_clk(sys_clk), .rst(rst),
    .blank_convert(blank_convert), .offset_open(offset_open), .comp_below(comp_below),
    .dac_code(dac_code), .offset_inject(offset_inject), .result_valid_n(result_valid_n),
    .data_out(data_out), .data_oe(data_oe));
  sacc_front_model u_sacc_front_model (.dac_code(dac_code), .vin(vin), .comp_below(comp_below));

  function automatic logic [7:0] exp_code(logic [8:0] v);
    return (v == 9'h000) ? 8'h00 : 8'(v - 9'h001);
  endfunction
  function automatic logic [7:0] lfsr_next(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(logic [7:0] seen, logic [7:0] want);
    samples_checked++;
    if (seen !== want) begin
      err_total++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One conversion, optionally halted after 500 cycles
  task automatic conv(logic [8:0] v, logic mode, int halt);
    vin = v;
    offset_open = mode;
    repeat (210) @(negedge sys_clk);
    blank_convert = 1'b0;
    if (halt > 0) begin
      repeat (500) @(negedge sys_clk);
      blank_convert = 1'b1;
      repeat (halt) @(negedge sys_clk);
      chk({data_oe[6:0], result_valid_n}, 8'h01);
      blank_convert = 1'b0;
    end
    cnt = 0;
    while (result_valid_n !== 1'b0) begin
      @(negedge sys_clk);
      cnt++;
      if (cnt > 3000) begin
        err_total++;
        close_out();
      end
    end
    if (halt == 0 || halt >= 210) chk(8'(cnt inside {[2496:2500]}), 8'h01);
    else chk(8'(cnt inside {[2184:2188]}), 8'h01);
    chk(data_out, exp_code(v));
    chk(data_oe, 8'hff);
    chk({7'h00, offset_inject}, {7'h00, mode});
    repeat (20) @(negedge sys_clk);
    chk({7'h00, result_valid_n}, 8'h00);
    blank_convert = 1'b1;
    repeat (149) @(negedge sys_clk);
    chk(data_oe, 8'hff);
    chk(dac_code, RESULT_RST);
    repeat (6) @(negedge sys_clk);
    chk({data_oe[6:0], result_valid_n}, 8'h01);
  endtask

  // Corners in both ranges, halts, then random inputs
  initial begin
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    for (int i = 0; i < 8; i++) conv(corner[i/2], i[0], 0);
    conv(9'h05a, 1'b0, 50);
    conv(9'h0c3, 1'b1, 230);
    repeat (6) begin
      lfsr = lfsr_next(lfsr);
      conv({1'b0, lfsr}, lfsr[0], 0);
    end
    close_out();
  end
endmodule
